//--- design/fdc_status_pkg.sv
// Package with command kinds, states, bit positions and counts for the result status block
package fdc_status_pkg;
  // Command kinds reported by the command engine
  typedef enum logic [3:0] {
    CMD_READ, CMD_WRITE, CMD_WRITE_DEL, CMD_FORMAT, CMD_SCAN,
    CMD_READ_ID, CMD_READ_CYL, CMD_SEEK, CMD_RECAL, CMD_OTHER
  } cmd_t;
  // Block state
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_RESULT} state_t;
  // Termination codes (top two bits of the first status byte)
  localparam logic [1:0] TERM_NORMAL = 2'h0;
  localparam logic [1:0] TERM_ABNORMAL = 2'h1;
  localparam logic [1:0] TERM_INVALID = 2'h2;
  localparam logic [1:0] TERM_READY_CHG = 2'h3;
  // First status byte bit positions
  localparam int TERM_HI_BIT = 7;
  localparam int TERM_LO_BIT = 6;
  localparam int SEEK_BIT = 5;
  localparam int EQUIP_BIT = 4;
  localparam int NREADY_BIT = 3;
  localparam int HEAD_BIT = 2;
  localparam int UNIT_HI_BIT = 1;
  localparam int UNIT_LO_BIT = 0;
  // Second status byte bit positions
  localparam int EOC_BIT = 7;
  localparam int CRC_BIT = 5;
  localparam int OVERRUN_BIT = 4;
  localparam int NODATA_BIT = 2;
  localparam int WPROT_BIT = 1;
  localparam int NOID_BIT = 0;
  // Result byte selector values
  localparam logic SEL_FIRST = 1'b0;
  localparam logic SEL_SECOND = 1'b1;
  // Step pulses allowed before recalibration gives up
  localparam logic [6:0] RECAL_STEP_LIMIT = 7'h4d;
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [6:0] STEP_RESET = 7'h00;
endpackage

//--- design/pin_sync.sv
// Two-stage synchroniser for one drive input pin
`timescale 1ns/1ps
module pin_sync (
  input wire logic clock, // Controller clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic pinIn, // Asynchronous pin level
  output logic pinSync // Level safe to use on clock
);
  logic meta_r; // First stage, read only by the second stage

  // Two flops to settle metastability before any logic looks at the pin
  always_ff @(posedge clock) begin
    if (!nrst) begin
      // Keep shifting during reset: a reset of two or more cycles then leaves the pin's
      // real level here, so the edge watch behind us sees no false edge at release
      meta_r <= pinIn;
      pinSync <= meta_r;
    end else begin
      meta_r <= pinIn;
      pinSync <= meta_r;
    end
  end
endmodule

//--- design/fdc_result_status_flags.sv
// Result-phase first and second status byte generation for the diskette controller
//
// Behaviour
// - Code 00 on correct completion
// - Code 01 when started command fails
// - Code 10 for invalid never-started command
// - Code 11 when ready changes mid-command
// - Seek-complete flag set when seek finishes
// - Equipment check on drive fault input
// - Equipment check after 77 steps without track zero
// - Not-ready when read/write hits unready drive
// - Not-ready for side 1 on single-sided during read/write
// - Bit 2 holds head at interrupt
// - Bits 1:0 hold unit at interrupt
// - End-of-cylinder when passing last sector
// - Second byte bits 6 and 3 zero
// - Data-error flag on any CRC failure
// - Overrun flag when transfer not serviced
// - No-data when read/write-deleted/scan misses sector
// - No-data when read ID finds no clean ID
// - No-data when read cylinder misses start
// - Not-writable on write-protect during writes/format
// - Missing-ID-mark flag when no ID mark
// - Missing ID mark also sets missing data mark
// - Missing data mark when no data mark
`timescale 1ns/1ps
module fdc_result_status_flags
  import fdc_status_pkg::*;
(
  input wire logic clock, // Controller clock, 100 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic cmdStart, // Pulse: a valid command begins execution
  input wire cmd_t cmdKind, // Kind of the starting command, valid with cmdStart
  input wire logic cmdInvalid, // Pulse: an invalid command was issued
  input wire logic cmdDone, // Pulse: execution ended, interrupt raised
  input wire logic cmdFailed, // With cmdDone: execution did not succeed
  input wire logic headSel, // Side selected by the engine
  input wire logic [1:0] unitSel, // Drive unit selected by the engine
  input wire logic stepPulse, // Pulse: one step pulse issued to the drive
  input wire logic seekDone, // Pulse: seek positioning finished
  input wire logic pastEndCyl, // Pulse: access beyond last sector
  input wire logic crcError, // Pulse: CRC failed in ID or data field
  input wire logic dataOverrun, // Pulse: transfer not serviced in time
  input wire logic sectorMiss, // Pulse: requested sector not found
  input wire logic idReadFail, // Pulse: no error-free ID field read
  input wire logic startSectorMiss, // Pulse: starting sector not found
  input wire logic noIdMark, // Pulse: ID address mark not detected
  input wire logic noDataMark, // Pulse: neither data nor deleted data mark
  input wire logic driveFaultPin, // Drive fault pin, asynchronous
  input wire logic trackZeroPin, // Drive track-zero pin, asynchronous
  input wire logic driveReadyPin, // Drive ready pin, asynchronous
  input wire logic writeProtPin, // Drive write-protect pin, asynchronous
  input wire logic twoSidedPin, // Drive two-sided pin, asynchronous
  input wire logic hostRd, // Pulse: host reads a result byte
  input wire logic hostSel, // Which byte: 0 first, 1 second
  output logic [7:0] rdData, // Result byte, registered
  output logic missingDataMark, // Missing data mark flag for third byte
  output logic resultPending // High while status bytes await reading
);
  state_t state_r; // Block state
  cmd_t kind_r; // Kind of the running command
  logic [1:0] term_r; // Termination code
  logic seek_r, equip_r, nready_r, head_r; // First byte flags
  logic [1:0] unit_r; // Unit at interrupt
  logic eoc_r, crc_r, overrun_r, nodata_r, wprot_r, noid_r, nodm_r; // Error flags
  logic readyChg_r; // Ready changed while executing
  logic readyPrev_r; // Ready level one cycle ago
  logic [6:0] steps_r; // Step pulses counted in recalibration
  logic secondRead_r; // Second byte has been read
  logic faultS, tzS, readyS, wpS, twoS; // Synchronised pins
  logic live; // Events are being captured
  logic isRdWr, isWriteKind, startRdWr; // Command classes
  logic [7:0] firstByte, secondByte; // Assembled status bytes
  logic recalGiveUp; // Recalibration failed to reach track zero
  logic startOk; // Start accepted, only outside execution

  // One synchroniser per drive pin
  pin_sync uFault (.clock(clock), .nrst(nrst), .pinIn(driveFaultPin), .pinSync(faultS));
  pin_sync uTz (.clock(clock), .nrst(nrst), .pinIn(trackZeroPin), .pinSync(tzS));
  pin_sync uReady (.clock(clock), .nrst(nrst), .pinIn(driveReadyPin), .pinSync(readyS));
  pin_sync uWp (.clock(clock), .nrst(nrst), .pinIn(writeProtPin), .pinSync(wpS));
  pin_sync uTwo (.clock(clock), .nrst(nrst), .pinIn(twoSidedPin), .pinSync(twoS));

  // Capture only while executing; frozen results stay put for the host
  assign live = (state_r == ST_EXEC);
  assign isRdWr = (kind_r inside {CMD_READ, CMD_WRITE, CMD_WRITE_DEL, CMD_SCAN, CMD_READ_ID, CMD_READ_CYL});
  assign isWriteKind = (kind_r inside {CMD_WRITE, CMD_WRITE_DEL, CMD_FORMAT});
  assign startRdWr = cmdKind inside {CMD_READ, CMD_WRITE, CMD_WRITE_DEL, CMD_SCAN, CMD_READ_ID, CMD_READ_CYL};
  assign recalGiveUp = live && (kind_r == CMD_RECAL) && (steps_r == RECAL_STEP_LIMIT) && !tzS;
  // A start during execution is ignored by the lifecycle, so it must not clear flags either
  assign startOk = cmdStart && !live;

  // Command lifecycle: idle, executing, result held until the second byte is read
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      kind_r <= CMD_OTHER;
      secondRead_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE, ST_RESULT: begin
          // A new command restarts even if the host skipped reading
          if (cmdStart) begin
            state_r <= ST_EXEC;
            kind_r <= cmdKind;
            secondRead_r <= 1'b0;
          end else if (cmdInvalid) begin
            state_r <= ST_RESULT;
            secondRead_r <= 1'b0;
          end else if (state_r == ST_RESULT && hostRd && hostSel == SEL_SECOND) begin
            secondRead_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_EXEC: begin
          if (cmdDone) begin
            state_r <= ST_RESULT;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Termination code, head and unit latched at interrupt
  always_ff @(posedge clock) begin
    if (!nrst) begin
      term_r <= TERM_NORMAL;
      head_r <= 1'b0;
      unit_r <= 2'h0;
    end else if (state_r != ST_EXEC && !cmdStart && cmdInvalid) begin
      term_r <= TERM_INVALID;
      head_r <= headSel;
      unit_r <= unitSel;
    end else if (live && cmdDone) begin
      head_r <= headSel;
      unit_r <= unitSel;
      if (readyChg_r || (readyPrev_r != readyS)) begin
        term_r <= TERM_READY_CHG;
      end else if (cmdFailed || nready_r) begin
        term_r <= TERM_ABNORMAL;
      end else begin
        term_r <= TERM_NORMAL;
      end
    end
  end

  // Ready watch during execution
  always_ff @(posedge clock) begin
    if (!nrst) begin
      readyPrev_r <= readyS; // Start from the settled level, no false edge
      readyChg_r <= 1'b0;
    end else begin
      readyPrev_r <= readyS;
      if (startOk) begin
        readyChg_r <= 1'b0;
      end else if (live && readyPrev_r != readyS) begin
        readyChg_r <= 1'b1;
      end
    end
  end

  // Step counter for recalibration; saturates at the limit
  always_ff @(posedge clock) begin
    if (!nrst) begin
      steps_r <= STEP_RESET;
    end else if (startOk) begin
      steps_r <= STEP_RESET;
    end else if (live && kind_r == CMD_RECAL && stepPulse && steps_r != RECAL_STEP_LIMIT) begin
      steps_r <= steps_r + 7'h01;
    end
  end

  // First byte flags; a start is taken only outside execution, where events are refused,
  // so the clear at start never hides an event in the same cycle
  always_ff @(posedge clock) begin
    if (!nrst) begin
      seek_r <= 1'b0;
      equip_r <= 1'b0;
      nready_r <= 1'b0;
    end else if (startOk) begin
      seek_r <= 1'b0;
      equip_r <= faultS;
      nready_r <= startRdWr && !readyS;
    end else if (live) begin
      seek_r <= seek_r | (seekDone && kind_r == CMD_SEEK);
      equip_r <= equip_r | faultS | recalGiveUp;
      nready_r <= nready_r | (isRdWr && ((!readyS) || (headSel && !twoS)));
    end
  end

  // Second byte error flags and missing data mark
  always_ff @(posedge clock) begin
    if (!nrst) begin
      eoc_r <= 1'b0;
      crc_r <= 1'b0;
      overrun_r <= 1'b0;
      nodata_r <= 1'b0;
      wprot_r <= 1'b0;
      noid_r <= 1'b0;
      nodm_r <= 1'b0;
    end else if (startOk) begin
      eoc_r <= 1'b0;
      crc_r <= 1'b0;
      overrun_r <= 1'b0;
      nodata_r <= 1'b0;
      wprot_r <= 1'b0;
      noid_r <= 1'b0;
      nodm_r <= 1'b0;
    end else if (live) begin
      eoc_r <= eoc_r | pastEndCyl;
      crc_r <= crc_r | crcError;
      overrun_r <= overrun_r | dataOverrun;
      nodata_r <= nodata_r
        | (sectorMiss && (kind_r inside {CMD_READ, CMD_WRITE_DEL, CMD_SCAN}))
        | (idReadFail && kind_r == CMD_READ_ID)
        | (startSectorMiss && kind_r == CMD_READ_CYL);
      wprot_r <= wprot_r | (isWriteKind && wpS);
      noid_r <= noid_r | noIdMark;
      nodm_r <= nodm_r | noIdMark | noDataMark;
    end
  end

  // Byte assembly; unused bits of the second byte stay low
  always_comb begin
    firstByte = STATUS_RESET;
    firstByte[TERM_HI_BIT:TERM_LO_BIT] = term_r;
    firstByte[SEEK_BIT] = seek_r;
    firstByte[EQUIP_BIT] = equip_r;
    firstByte[NREADY_BIT] = nready_r;
    firstByte[HEAD_BIT] = head_r;
    firstByte[UNIT_HI_BIT:UNIT_LO_BIT] = unit_r;
    secondByte = STATUS_RESET;
    secondByte[EOC_BIT] = eoc_r;
    secondByte[CRC_BIT] = crc_r;
    secondByte[OVERRUN_BIT] = overrun_r;
    secondByte[NODATA_BIT] = nodata_r;
    secondByte[WPROT_BIT] = wprot_r;
    secondByte[NOID_BIT] = noid_r;
  end

  // Host read port: data registered one cycle after the read strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdData <= STATUS_RESET;
    end else if (hostRd) begin
      rdData <= (hostSel == SEL_SECOND) ? secondByte : firstByte;
    end
  end

  assign missingDataMark = nodm_r;
  assign resultPending = (state_r == ST_RESULT) && !secondRead_r;

  chk_invalid_code: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == ST_IDLE && cmdInvalid && !cmdStart) |=> term_r == TERM_INVALID)
    else $error("invalid command did not give code 10");
  chk_ready_code: assert property (@(posedge clock) disable iff (!nrst)
    (live && readyChg_r && cmdDone) |=> term_r == TERM_READY_CHG)
    else $error("ready change did not give code 11");
  chk_fail_code: assert property (@(posedge clock) disable iff (!nrst)
    (live && cmdDone && cmdFailed && !readyChg_r && readyPrev_r == readyS) |=> term_r == TERM_ABNORMAL)
    else $error("failed command did not give code 01");
  chk_fault_equip: assert property (@(posedge clock) disable iff (!nrst)
    (live && faultS && !cmdDone) |=> equip_r)
    else $error("fault did not set equipment check");
  chk_recal_limit: assert property (@(posedge clock) disable iff (!nrst)
    (steps_r != STEP_RESET) |-> steps_r <= RECAL_STEP_LIMIT)
    else $error("step count passed the limit");
  chk_unused_zero: assert property (@(posedge clock) disable iff (!nrst)
    $past(hostRd) && $past(hostSel) |-> rdData[6] == 1'b0 && rdData[3] == 1'b0)
    else $error("unused second byte bits not zero");
  chk_id_data_mark: assert property (@(posedge clock) disable iff (!nrst)
    noid_r |-> nodm_r)
    else $error("missing ID mark without missing data mark");
  chk_held_result: assert property (@(posedge clock) disable iff (!nrst)
    (state_r == ST_RESULT && !cmdStart && !cmdInvalid) |=> $stable(secondByte) && $stable(term_r))
    else $error("status changed while held for host");
  chk_crc_flag: assert property (@(posedge clock) disable iff (!nrst)
    (live && crcError) |=> ##[0:1] crc_r)
    else $error("CRC error not flagged");
  // Flag setting and clearing, each watched where its condition arises
  chk_normal_code: assert property (@(posedge clock) disable iff (!nrst)
    (live && cmdDone && !cmdFailed && !nready_r && !readyChg_r && readyPrev_r == readyS) |=> term_r == TERM_NORMAL)
    else $error("clean completion did not give code 00");
  chk_seek_flag: assert property (@(posedge clock) disable iff (!nrst)
    (live && kind_r == CMD_SEEK && seekDone) |=> seek_r)
    else $error("seek end not flagged");
  chk_recal_equip: assert property (@(posedge clock) disable iff (!nrst)
    (live && kind_r == CMD_RECAL && steps_r == RECAL_STEP_LIMIT && !tzS) |=> equip_r)
    else $error("recalibration give-up not flagged");
  chk_not_ready: assert property (@(posedge clock) disable iff (!nrst)
    (live && isRdWr && !readyS) |=> nready_r)
    else $error("unready drive not flagged");
  chk_single_side: assert property (@(posedge clock) disable iff (!nrst)
    (live && isRdWr && headSel && !twoS) |=> nready_r)
    else $error("side 1 of single-sided drive not flagged");
  chk_wprot_flag: assert property (@(posedge clock) disable iff (!nrst)
    (live && isWriteKind && wpS) |=> wprot_r)
    else $error("write protect not flagged");
  chk_head_unit: assert property (@(posedge clock) disable iff (!nrst)
    (live && cmdDone) |=> head_r == $past(headSel) && unit_r == $past(unitSel))
    else $error("head or unit not latched at interrupt");
  chk_start_clear: assert property (@(posedge clock) disable iff (!nrst)
    (startOk && !faultS) |=> !seek_r && !equip_r && !eoc_r && !crc_r && !noid_r && !nodm_r)
    else $error("flags not cleared at command start");
endmodule

//--- tb/fdc_host_model.sv
// Host model that reads the two result status bytes
`timescale 1ns/1ps
module fdc_host_model
  import fdc_status_pkg::*;
(
  input wire logic clock, // Controller clock
  input wire logic [7:0] rdData, // Result byte from the block
  output logic hostRd, // Read strobe
  output logic hostSel // Byte selector
);
  // Idle: no strobe, selector parked
  initial begin
    hostRd = 1'h0;
    hostSel = SEL_SECOND;
  end
  // Reads both bytes back to back, first then second
  task automatic readResult(output logic [7:0] b0, output logic [7:0] b1);
    @(negedge clock);
    hostRd = 1'h1;
    hostSel = SEL_FIRST;
    @(negedge clock);
    b0 = rdData;
    hostSel = SEL_SECOND;
    @(negedge clock);
    b1 = rdData;
    hostRd = 1'h0;
    // Selector no longer qualified, so do not leave the old value
    hostSel = ~hostSel;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the result status byte block
`timescale 1ns/1ps
module tb
  import fdc_status_pkg::*;
;
  logic clock = 1'h0; // Controller clock
  logic nrst = 1'h0; // Reset, active low
  logic cmdStart, cmdInvalid, cmdDone, cmdFailed, headSel, stepPulse; // Engine strobes
  cmd_t cmdKind; // Command kind
  logic [1:0] unitSel; // Unit number
  logic [8:0] evVec; // Event pulses, one bit per event input
  logic driveFaultPin, trackZeroPin, driveReadyPin, writeProtPin, twoSidedPin; // Drive pins
  logic hostRd, hostSel, missingDataMark, resultPending; // Host side
  logic [7:0] rdData; // Result byte
  int failures = 0; // Mismatch count
  int nChecks = 0; // Comparison count
  int cycles = 0; // Hang guard
  integer seed = 32'h7ff9727a; // Fixed seed
  cmd_t wk[3] = '{CMD_WRITE, CMD_WRITE_DEL, CMD_FORMAT}; // Writing kinds

  always #5 clock = ~clock;

  fdc_result_status_flags dut_u (.clock(clock), .nrst(nrst), .cmdStart(cmdStart), .cmdKind(cmdKind),
    .cmdInvalid(cmdInvalid), .cmdDone(cmdDone), .cmdFailed(cmdFailed), .headSel(headSel),
    .unitSel(unitSel), .stepPulse(stepPulse), .seekDone(evVec[8]), .pastEndCyl(evVec[0]),
    .crcError(evVec[1]), .dataOverrun(evVec[2]), .sectorMiss(evVec[3]), .idReadFail(evVec[4]),
    .startSectorMiss(evVec[5]), .noIdMark(evVec[6]), .noDataMark(evVec[7]),
    .driveFaultPin(driveFaultPin), .trackZeroPin(trackZeroPin), .driveReadyPin(driveReadyPin),
    .writeProtPin(writeProtPin), .twoSidedPin(twoSidedPin), .hostRd(hostRd), .hostSel(hostSel),
    .rdData(rdData), .missingDataMark(missingDataMark), .resultPending(resultPending));

  fdc_host_model host_u (.clock(clock), .rdData(rdData), .hostRd(hostRd), .hostSel(hostSel));

  // One comparison, counted
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One command; opt bits: 5 ready, 4 protect, 3 two-sided, 2 fault, 1 failed, 0 ready drop
  task automatic runCmd(input cmd_t k, input logic [8:0] ev, input int steps, input logic [5:0] opt);
    logic [7:0] b0, b1, e0, e1;
    logic hd, nr, rw;
    logic [1:0] un, term;
    hd = opt[3] ? 1'($random(seed)) : 1'h1;
    un = 2'($random(seed));
    @(negedge clock);
    {driveReadyPin, writeProtPin, twoSidedPin, driveFaultPin} = opt[5:2];
    headSel = hd;
    unitSel = un;
    // Pins pass a synchroniser, so let them settle first
    repeat (4) @(negedge clock);
    cmdStart = 1'h1;
    cmdKind = k;
    @(negedge clock);
    cmdStart = 1'h0;
    for (int i = 0; i < 9; i++) begin
      evVec = ev & (9'h1 << i);
      @(negedge clock);
    end
    evVec = 9'h0;
    repeat (steps) begin
      stepPulse = 1'h1;
      @(negedge clock);
    end
    stepPulse = 1'h0;
    if (opt[0]) begin
      driveReadyPin = ~opt[5];
      repeat (4) @(negedge clock);
    end
    cmdDone = 1'h1;
    cmdFailed = opt[1];
    @(negedge clock);
    cmdDone = 1'h0;
    // A late CRC pulse after completion must not reach the bytes
    evVec = 9'h002;
    @(negedge clock);
    evVec = 9'h0;
    rw = k inside {CMD_READ, CMD_WRITE, CMD_WRITE_DEL, CMD_SCAN, CMD_READ_ID, CMD_READ_CYL};
    nr = rw && (!opt[5] || (hd && !opt[3]));
    term = opt[0] ? TERM_READY_CHG : (opt[1] || nr) ? TERM_ABNORMAL : TERM_NORMAL;
    e0 = {term, ev[8], opt[2] || (k == CMD_RECAL && steps >= 77 && !trackZeroPin), nr, hd, un};
    e1 = {ev[0], 1'h0, ev[1], ev[2], 1'h0, |ev[5:3], opt[4] && k inside {wk}, ev[6]};
    check("pending", 8'h01, {7'h0, resultPending});
    check("datamark", {7'h0, ev[6] | ev[7]}, {7'h0, missingDataMark});
    host_u.readResult(b0, b1);
    check("first", e0, b0);
    check("second", e1, b1);
    check("pending", 8'h00, {7'h0, resultPending});
    $display("test kind %0d done", k);
  endtask

  // Invalid command: code, head and unit only
  task automatic runInvalid();
    logic [7:0] b0, b1;
    logic hd;
    logic [1:0] un;
    hd = 1'($random(seed));
    un = 2'($random(seed));
    @(negedge clock);
    headSel = hd;
    unitSel = un;
    cmdInvalid = 1'h1;
    @(negedge clock);
    cmdInvalid = 1'h0;
    host_u.readResult(b0, b1);
    check("invalid", {TERM_INVALID, 3'h0, hd, un}, b0 & 8'hc7);
    $display("test invalid done");
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    {cmdStart, cmdInvalid, cmdDone, cmdFailed, headSel, stepPulse, trackZeroPin} = 7'h0;
    {driveFaultPin, writeProtPin} = 2'h0;
    {driveReadyPin, twoSidedPin} = 2'h3;
    cmdKind = CMD_OTHER;
    unitSel = 2'h0;
    evVec = 9'h0;
    repeat (12) @(negedge clock);
    nrst = 1'h1;
    @(negedge clock);
    check("reset pending", 8'h00, {7'h0, resultPending});
    check("reset data", STATUS_RESET, rdData);
    runCmd(CMD_READ, 9'h002, 0, 6'h2a);
    runCmd(CMD_READ, 9'h000, 0, 6'h28);
    runCmd(CMD_READ, 9'h00d, 0, 6'h2a);
    runCmd(CMD_SCAN, 9'h008, 0, 6'h2a);
    runCmd(CMD_READ_ID, 9'h050, 0, 6'h2a);
    runCmd(CMD_READ_CYL, 9'h0a0, 0, 6'h2a);
    foreach (wk[i]) runCmd(wk[i], 9'h000, 0, 6'h3a);
    runCmd(CMD_SEEK, 9'h100, 0, 6'h38);
    runCmd(CMD_RECAL, 9'h000, 77, 6'h2a);
    runCmd(CMD_RECAL, 9'h000, 76, 6'h28);
    // Track zero seen: no equipment check even after the full step count
    trackZeroPin = 1'h1;
    runCmd(CMD_RECAL, 9'h000, 77, 6'h28);
    trackZeroPin = 1'h0;
    runCmd(CMD_READ, 9'h000, 0, 6'h08);
    runCmd(CMD_READ, 9'h000, 0, 6'h20);
    runCmd(CMD_OTHER, 9'h000, 0, 6'h2e);
    runCmd(CMD_SEEK, 9'h000, 0, 6'h29);
    runInvalid();
    summarize();
  end
endmodule
